// ==== verilog/opcode_field_decoder.sv ====
// Opcode field decoder with its table, status and working registers behind an APB slave.
//
// Function
// - File operand is full 8-bit address
// - Peripheral operand is 5-bit address
// - Pointer control one increments table pointer
// - Byte select picks low or high half
// - Bit select picks one of eight
// - Destination zero goes to accumulator only
// - Alternate zero writes file and accumulator
// - Don't-care bits never change behaviour
// - Interrupt disable is status bit four
// - Table latch is two byte halves
// - ALU keeps carry, digit, zero, overflow
// - Instruction is one 16-bit word
// - Instruction cycle is four oscillator periods
// - Table operations add one idle cycle
// - Literal is eight or eleven bits
`timescale 1ns/100ps
module opcode_field_decoder
    import opcode_field_pkg::*;
#(
    parameter int CYCLE_LEN = CYCLE_CLOCKS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  file_addr,
    output logic      [4:0]  periph_addr,
    output logic      [7:0]  bit_mask,
    output logic      [10:0] literal,
    output logic             file_we,
    output logic      [7:0]  file_wdata,
    output logic      [7:0]  working_accumulator,
    output logic             global_irq_disable,
    output logic      [15:0] table_pointer,
    output logic      [15:0] table_latch,
    output logic             busy
);
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [15:0] instr_reg;
    logic [2:0]  fmt_reg;
    logic [7:0]  result_reg;
    logic [7:0]  accum_reg;
    logic [7:0]  cpu_status_reg;
    logic [3:0]  flags_reg;
    logic [15:0] table_ptr_reg;
    logic [15:0] table_latch_reg;
    logic        busy_reg;
    logic [7:0]  file_addr_reg;
    logic [4:0]  periph_addr_reg;
    logic [7:0]  bit_mask_reg;
    logic [10:0] literal_reg;
    logic        file_we_reg;
    logic        file_we_next;
    logic [7:0]  file_wdata_reg;
    logic [7:0]  file_wdata_next;
    logic [7:0]  cnt_reg;
    state_type   state_reg;
    state_type   state_next;
    logic [31:0] rdata_next;
    logic        err_next;

    wire        apb_go    = psel & penable & pready_reg;
    wire        wr_en     = apb_go & pwrite;
    wire        idle      = state_reg == ST_IDLE;
    wire        start     = wr_en & (paddr == OFF_INSTR) & idle;
    wire [15:0] fmt_mask  = (fmt_reg == FMT_LIT8) ? MASK_LIT8 : MASK_ALL;
    wire [15:0] new_instr = pwdata[INSTR_W-1:0] & fmt_mask;
    wire [2:0]  new_bit   = new_instr[B_LSB +: B_W];
    wire [2:0]  bit_sel   = instr_reg[B_LSB +: B_W];
    wire        d_sel     = instr_reg[D_BIT];
    wire        s_sel     = instr_reg[S_BIT];
    wire        i_sel     = instr_reg[I_BIT];
    wire        t_sel     = instr_reg[T_BIT];
    wire        cycle_end = !idle && (cnt_reg == 8'(CYCLE_LEN - 1));
    wire        commit    = (state_reg == ST_EXEC) && cycle_end;
    wire        is_table  = fmt_reg == FMT_TABLE;
    wire        finish    = cycle_end && (state_reg == ST_NOP || !is_table);
    wire        byte_acc  = commit && fmt_reg == FMT_BYTE && !d_sel;
    wire        s_acc     = commit && fmt_reg == FMT_BYTE_S && !s_sel;
    wire        lit_acc   = commit && fmt_reg == FMT_LIT8;
    wire [7:0]  acc_val   = lit_acc ? instr_reg[K8_W-1:0] : result_reg;
    wire        z_update  = byte_acc | s_acc | lit_acc | (commit && fmt_reg == FMT_BYTE && d_sel);
    wire [7:0]  onehot;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_bit
            assign onehot[g] = new_bit == 3'(g);
        end
    endgenerate

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign file_addr           = file_addr_reg;
    assign periph_addr         = periph_addr_reg;
    assign bit_mask            = bit_mask_reg;
    assign literal             = literal_reg;
    assign file_we             = file_we_reg;
    assign file_wdata          = file_wdata_reg;
    assign working_accumulator = accum_reg;
    assign global_irq_disable  = cpu_status_reg[IRQ_DIS_BIT];
    assign table_pointer       = table_ptr_reg;
    assign table_latch         = table_latch_reg;
    assign busy                = busy_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        unique case (paddr)
            OFF_INSTR:  rdata_next = {16'h0000, instr_reg};
            OFF_FORMAT: rdata_next = {29'h0, fmt_reg};
            OFF_RESULT: rdata_next = {24'h0, result_reg};
            OFF_ACCUM:       rdata_next = {24'h0, accum_reg};
            OFF_CPU_STATUS:  rdata_next = {24'h0, cpu_status_reg};
            OFF_FLAGS:       rdata_next = {28'h0, flags_reg};
            OFF_TABLE_PTR:   rdata_next = {16'h0000, table_ptr_reg};
            OFF_TABLE_LATCH: rdata_next = {16'h0000, table_latch_reg};
            OFF_STATUS: rdata_next = {31'h0, !idle};
            default:    err_next   = 1'b1;
        endcase
    end

    always_comb begin
        file_we_next    = 1'b0;
        file_wdata_next = file_wdata_reg;
        if (commit) begin
            unique case (fmt_reg)
                FMT_BYTE: begin
                    file_we_next    = d_sel;
                    file_wdata_next = result_reg;
                end
                FMT_BYTE_S: begin
                    file_we_next    = 1'b1;
                    file_wdata_next = result_reg;
                end
                FMT_BIT: begin
                    file_we_next    = 1'b1;
                    file_wdata_next = result_reg | bit_mask_reg;
                end
                default: file_we_next = 1'b0;
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (start) state_next = ST_EXEC;
            ST_EXEC: if (cycle_end) state_next = is_table ? ST_NOP : ST_IDLE;
            ST_NOP:  if (cycle_end) state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel & penable & !pready_reg;
            prdata_reg  <= (psel & penable & !pready_reg & !pwrite) ? rdata_next : 32'h0000_0000;
            pslverr_reg <= psel & penable & !pready_reg & err_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            busy_reg  <= state_next != ST_IDLE;
            cnt_reg   <= (start || cycle_end) ? 8'h00 : cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            instr_reg       <= 16'h0000;
            file_addr_reg   <= 8'h00;
            periph_addr_reg <= 5'h00;
            bit_mask_reg    <= 8'h01;
            literal_reg     <= 11'h000;
        end else if (start) begin
            instr_reg       <= new_instr;
            file_addr_reg   <= new_instr[F_LSB +: F_W];
            periph_addr_reg <= new_instr[P_LSB +: P_W];
            bit_mask_reg    <= onehot;
            literal_reg     <= (fmt_reg == FMT_LIT11) ? new_instr[K11_W-1:0]
                                                      : {3'h0, new_instr[K8_W-1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            file_we_reg    <= 1'b0;
            file_wdata_reg <= 8'h00;
            fmt_reg        <= FORMAT_RESET;
            result_reg     <= 8'h00;
            cpu_status_reg <= CPU_STATUS_RESET;
        end else begin
            file_we_reg    <= file_we_next;
            file_wdata_reg <= file_wdata_next;
            if (wr_en && paddr == OFF_FORMAT && idle) fmt_reg <= pwdata[2:0];
            if (wr_en && paddr == OFF_RESULT && idle) result_reg <= pwdata[7:0];
            if (wr_en && paddr == OFF_CPU_STATUS) cpu_status_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            accum_reg <= 8'h00;
            flags_reg <= 4'h0;
        end else begin
            if (byte_acc || s_acc || lit_acc) accum_reg <= acc_val;
            else if (wr_en && paddr == OFF_ACCUM) accum_reg <= pwdata[7:0];
            if (z_update) flags_reg[Z_BIT] <= (lit_acc ? acc_val : result_reg) == 8'h00;
            else if (wr_en && paddr == OFF_FLAGS) flags_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            table_ptr_reg   <= 16'h0000;
            table_latch_reg <= 16'h0000;
        end else begin
            if (finish && is_table && i_sel) table_ptr_reg <= table_ptr_reg + 16'h0001;
            else if (wr_en && paddr == OFF_TABLE_PTR) table_ptr_reg <= pwdata[15:0];
            if (commit && is_table && t_sel) table_latch_reg[15:8] <= result_reg;
            else if (commit && is_table) table_latch_reg[7:0] <= result_reg;
            else if (wr_en && paddr == OFF_TABLE_LATCH) table_latch_reg <= pwdata[15:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence seq_exec;
        (state_reg == ST_EXEC) [*4];
    endsequence
    sequence seq_nop;
        (state_reg == ST_NOP) [*4];
    endsequence

    AST_FILE_ADDR: assert property (start |=> file_addr_reg == $past(pwdata[7:0]))
        else $error("File address not taken from low byte.");
    AST_PERIPH_ADDR: assert property (start |=> periph_addr_reg ==
        ($past(pwdata[12:8]) & ((fmt_reg == FMT_LIT8) ? 5'h1C : 5'h1F)))
        else $error("Peripheral address field wrong.");
    AST_PTR_INC: assert property (finish && is_table && i_sel
        |=> table_ptr_reg == $past(table_ptr_reg) + 16'h0001)
        else $error("Table pointer did not increment.");
    AST_PTR_HOLD: assert property (!idle && is_table && !i_sel |=> table_ptr_reg == $past(table_ptr_reg))
        else $error("Table pointer changed without increment control.");
    AST_TBL_LOW: assert property (commit && is_table && !t_sel |=> table_latch_reg[7:0] == $past(result_reg)
        && table_latch_reg[15:8] == $past(table_latch_reg[15:8]))
        else $error("Low table byte operation wrong.");
    AST_BIT_SEL: assert property (!idle |-> $onehot(bit_mask_reg) && bit_mask_reg[bit_sel])
        else $error("Bit select mask is not the addressed bit.");
    AST_DEST_D0: assert property (byte_acc |=> accum_reg == $past(result_reg) && !file_we_reg)
        else $error("Destination zero did not go only to accumulator.");
    AST_DEST_S0: assert property (s_acc |=> accum_reg == $past(result_reg) && file_we_reg)
        else $error("Alternate destination zero did not write both.");
    AST_DONT_CARE: assert property (start && fmt_reg == FMT_LIT8 |=> instr_reg[9:8] == 2'h0)
        else $error("Don't-care bits reached the decoder.");
    AST_IRQ_DISABLE: assert property (wr_en && paddr == OFF_CPU_STATUS
        |=> global_irq_disable == $past(pwdata[4]))
        else $error("Interrupt disable not at status bit four.");
    AST_ZERO: assert property (z_update && !lit_acc |=> flags_reg[Z_BIT] == ($past(result_reg) == 8'h00))
        else $error("Zero flag not updated from result.");
    AST_ONE_CYCLE: assert property (start && fmt_reg != FMT_TABLE |=> seq_exec ##1 idle)
        else $error("Instruction cycle is not four clocks.");
    AST_TABLE_TWO: assert property (start && fmt_reg == FMT_TABLE |=> seq_exec ##1 seq_nop ##1 idle)
        else $error("Table operation is not two cycles.");
endmodule

// ==== verilog/opcode_field_pkg.sv ====
// Constants for the opcode field decoder: register map, field layout, formats and timing.
package opcode_field_pkg;
    localparam logic [7:0] OFF_INSTR   = 8'h00;
    localparam logic [7:0] OFF_FORMAT  = 8'h04;
    localparam logic [7:0] OFF_RESULT  = 8'h08;
    localparam logic [7:0] OFF_ACCUM       = 8'h0C;
    localparam logic [7:0] OFF_CPU_STATUS  = 8'h10;
    localparam logic [7:0] OFF_FLAGS       = 8'h14;
    localparam logic [7:0] OFF_TABLE_PTR   = 8'h18;
    localparam logic [7:0] OFF_TABLE_LATCH = 8'h1C;
    localparam logic [7:0] OFF_STATUS  = 8'h20;

    localparam int F_LSB     = 0;
    localparam int F_W       = 8;
    localparam int P_LSB     = 8;
    localparam int P_W       = 5;
    localparam int B_LSB     = 8;
    localparam int B_W       = 3;
    localparam int D_BIT     = 8;
    localparam int S_BIT     = 8;
    localparam int I_BIT     = 8;
    localparam int T_BIT     = 9;
    localparam int K8_W      = 8;
    localparam int K11_W     = 11;
    localparam int INSTR_W   = 16;
    localparam int IRQ_DIS_BIT = 4;
    localparam int C_BIT     = 0;
    localparam int DIGIT_BIT = 1;
    localparam int Z_BIT     = 2;
    localparam int OVFL_BIT  = 3;

    localparam logic [2:0] FMT_BYTE   = 3'h0;
    localparam logic [2:0] FMT_BIT    = 3'h1;
    localparam logic [2:0] FMT_PERIPH = 3'h2;
    localparam logic [2:0] FMT_TABLE  = 3'h3;
    localparam logic [2:0] FMT_LIT8   = 3'h4;
    localparam logic [2:0] FMT_LIT11  = 3'h5;
    localparam logic [2:0] FMT_BYTE_S = 3'h6;

    localparam logic [15:0] MASK_ALL  = 16'hFFFF;
    localparam logic [15:0] MASK_LIT8 = 16'hFCFF;

    localparam logic [7:0]  CPU_STATUS_RESET = 8'h10;
    localparam logic [2:0]  FORMAT_RESET = 3'h0;

    localparam int OSC_PERIOD_NS   = 5;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int INSTR_CYCLE_OSC = 4;
    localparam int TABLE_CYCLES    = 2;
    localparam int CYCLE_CLOCKS    = INSTR_CYCLE_OSC * OSC_PERIOD_NS / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} state_type;
endpackage

// ==== testbench/program_image.sv ====
// Program memory model that encodes instruction words for each format.
`timescale 1ns/100ps
module program_image
    import opcode_field_pkg::*;
(
    input  wire logic [2:0]  fmt,
    input  wire logic [7:0]  f_field,
    input  wire logic [2:0]  sel,
    input  wire logic [4:0]  p_field,
    input  wire logic [10:0] k_field,
    input  wire logic [1:0]  loose,
    output logic      [15:0] word
);
    // Unused positions are encoded as zero; only the 8-bit literal form carries loose bits.
    always_comb begin
        case (fmt)
            FMT_BIT:    word = {5'h00, sel, f_field};
            FMT_PERIPH: word = {3'h0, p_field, f_field};
            FMT_TABLE:  word = {6'h00, sel[1:0], f_field};
            FMT_LIT8:   word = {6'h00, loose, k_field[7:0]};
            FMT_LIT11:  word = {5'h00, k_field};
            default:    word = {7'h00, sel[0], f_field};
        endcase
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the opcode field decoder.
`timescale 1ns/100ps
module tb_top
    import opcode_field_pkg::*;
;
    typedef struct packed {logic [31:0] data; logic err;} bus_exp_type;
    typedef struct packed {logic [7:0] fa; logic [4:0] pa; logic [7:0] bm; logic [10:0] lit; logic [4:0] len;} instr_exp_type;
    typedef struct packed {logic [7:0] fa; logic [7:0] data;} we_exp_type;
    localparam int CL = 4;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, we_free = 1'b0;
    logic [7:0]  paddr = 8'h00, acc = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, file_we, global_irq_disable, busy;
    logic [7:0]  file_addr, bit_mask, file_wdata, working_accumulator;
    logic [4:0]  periph_addr, pm_p = 5'h00, blen = 5'h00;
    logic [10:0] literal, pm_k = 11'h000;
    logic [15:0] table_pointer, table_latch, pm_word, tlat = 16'h0000, tptr = 16'h0000;
    logic [2:0]  pm_fmt = 3'h0, pm_sel = 3'h0;
    logic [7:0]  pm_f = 8'h00;
    logic [1:0]  pm_x = 2'h0;
    logic [3:0]  flg = 4'h0;
    int          n_fail = 0, num_checks = 0, cycles = 0;
    bus_exp_type   bq[$];
    instr_exp_type iq[$];
    we_exp_type    wq[$];

    always #2.5 clock = ~clock;

    opcode_field_decoder #(.CYCLE_LEN(CL)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .file_addr(file_addr), .periph_addr(periph_addr), .bit_mask(bit_mask), .literal(literal),
        .file_we(file_we), .file_wdata(file_wdata), .working_accumulator(working_accumulator),
        .global_irq_disable(global_irq_disable), .table_pointer(table_pointer), .table_latch(table_latch),
        .busy(busy));
    program_image image (.fmt(pm_fmt), .f_field(pm_f), .sel(pm_sel), .p_field(pm_p), .k_field(pm_k),
        .loose(pm_x), .word(pm_word));

    task chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_bus(input bus_exp_type e);
        chk_val("bus answer", {e.data, e.err}, {prdata, pslverr});
    endtask
    task chk_instr(input instr_exp_type e);
        chk_val("fields", {e.fa, e.pa, e.bm, e.lit}, {file_addr, periph_addr, bit_mask, literal});
        chk_val("busy length", e.len, blen);
    endtask
    task chk_we(input we_exp_type e);
        chk_val("file write", {e.fa, e.data}, {file_addr, file_wdata});
    endtask
    task finish_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic err);
        int n;
        n = 0;
        bq.push_back('{e, err});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    task run(input logic [2:0] fm, input logic [2:0] sl, input logic [7:0] f, input logic [7:0] res);
        logic [15:0] w;
        logic [15:0] m;
        int n;
        pm_fmt = fm;
        pm_sel = sl;
        pm_f = f;
        pm_p = 5'($urandom);
        pm_k = {3'($urandom), f};
        pm_x = 2'($urandom);
        wr(OFF_FORMAT, {29'h0, fm});
        wr(OFF_RESULT, {24'h0, res});
        w = pm_word;
        m = w & ((fm == FMT_LIT8) ? MASK_LIT8 : MASK_ALL);
        we_free = (fm == FMT_PERIPH || fm == FMT_TABLE || fm == FMT_LIT11);
        iq.push_back('{m[7:0], m[12:8], 8'h01 << m[10:8], (fm == FMT_LIT11) ? m[10:0] : {3'h0, m[7:0]},
                      (fm == FMT_TABLE) ? 5'(2 * CL) : 5'(CL)});
        if (fm == FMT_LIT8 || (fm == FMT_BYTE || fm == FMT_BYTE_S) && !sl[0]) acc = (fm == FMT_LIT8) ? w[7:0] : res;
        if (fm == FMT_BYTE_S || fm == FMT_BYTE && sl[0]) wq.push_back('{w[7:0], res});
        if (fm == FMT_BIT) wq.push_back('{w[7:0], res | (8'h01 << sl)});
        if (fm == FMT_LIT8 || fm == FMT_BYTE || fm == FMT_BYTE_S) flg[Z_BIT] = ((fm == FMT_LIT8 ? w[7:0] : res) == 8'h00);
        if (fm == FMT_TABLE && sl[1]) tlat[15:8] = res;
        if (fm == FMT_TABLE && !sl[1]) tlat[7:0] = res;
        if (fm == FMT_TABLE && sl[0]) tptr = tptr + 16'h0001;
        wr(OFF_INSTR, {16'h0, w});
        n = 0;
        while (busy !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        while (busy === 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        @(posedge clock);
        rd(OFF_ACCUM, {24'h0, acc});
        rd(OFF_FLAGS, {28'h0, flg});
        rd(OFF_TABLE_LATCH, {16'h0, tlat});
        rd(OFF_TABLE_PTR, {16'h0, tptr});
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            finish_test;
        end
    end

    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && bq.size() > 0) chk_bus(bq.pop_front());
        if (file_we === 1'b1 && wq.size() > 0) chk_we(wq.pop_front());
        else if (file_we === 1'b1 && !we_free) chk_val("stray write", 1'b0, 1'b1);
        if (busy === 1'b1) blen <= blen + 5'h01;
        else if (blen != 5'h00) begin
            blen <= 5'h00;
            if (iq.size() > 0) chk_instr(iq.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h978B));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(OFF_CPU_STATUS, 32'h10);
        wr(OFF_CPU_STATUS, 32'h0);
        chk_val("irq disable", 1'b0, global_irq_disable);
        wr(OFF_CPU_STATUS, 32'h10);
        chk_val("irq disable", 1'b1, global_irq_disable);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'hFC, 32'h1, 32'h0, 1'b1);
        wr(OFF_FLAGS, 32'hB);
        flg = 4'hB;
        wr(OFF_TABLE_PTR, 32'hFFFF);
        tptr = 16'hFFFF;
        for (int i = 0; i < 2; i++) begin
            run(FMT_BYTE, 3'(i), 8'h00, 8'(i * 8'h5A));
            run(FMT_BYTE_S, 3'(i), 8'hFF, 8'($urandom));
            run(FMT_PERIPH, 3'h0, 8'($urandom), 8'($urandom));
        end
        for (int b = 0; b < 8; b++) run(FMT_BIT, 3'(b), 8'($urandom), 8'($urandom));
        run(FMT_TABLE, 3'h1, 8'($urandom), 8'hA5);
        run(FMT_TABLE, 3'h2, 8'($urandom), 8'h3C);
        run(FMT_LIT8, 3'h0, 8'h00, 8'($urandom));
        run(FMT_LIT8, 3'h0, 8'h5A, 8'($urandom));
        run(FMT_LIT11, 3'h0, 8'($urandom), 8'($urandom));
        chk_val("pending writes", 64'h0, 64'(wq.size()));
        finish_test;
    end
endmodule
